/* hw/hrf_map.vh */
// Overview of operation
// - only initial register reachable before initialization
// - uninitialized writes all land in initial register
// - after initialization initial register accesses ignored
// - active state reads return true register values
// - sleep reads show retained bits, others zero
// - leave reset in sleep power state
// - dma counter wrap sets sticky status bit
`ifndef HRF_MAP_VH
`define HRF_MAP_VH

// register indices; byte address is four times the index
`define HRF_IDX_MAIN_ST   10'h000
`define HRF_IDX_DEV_ST    10'h001
`define HRF_IDX_HOST_ST   10'h002
`define HRF_IDX_CPU_ST    10'h003
`define HRF_IDX_FIFO_ST   10'h004
`define HRF_IDX_MAIN_EN   10'h008
`define HRF_IDX_DEV_EN    10'h009
`define HRF_IDX_HOST_EN   10'h00a
`define HRF_IDX_CPU_EN    10'h00b
`define HRF_IDX_FIFO_EN   10'h00c
`define HRF_IDX_REV       10'h010
`define HRF_IDX_CHIP_RST  10'h011
`define HRF_IDX_PM_CTRL   10'h012
`define HRF_IDX_WAKE_HI   10'h014
`define HRF_IDX_WAKE_LO   10'h015
`define HRF_IDX_HOST_CTRL 10'h016
`define HRF_IDX_INIT_CFG  10'h07e

// implemented bits of each group status register, and of the main enable register
`define HRF_DEV_BITS      8'hbb
`define HRF_HOST_BITS     8'hfb
`define HRF_CPU_BITS      8'h83
`define HRF_FIFO_BITS     8'h87
`define HRF_MAIN_EN_BITS  8'hf1

// field positions
`define HRF_INIT_ENDIAN   10
`define HRF_INIT_BUSW     9
`define HRF_CPU_DMA_WRAP  1
`define HRF_PM_GO_SLEEP   7
`define HRF_PM_GO_ACTIVE  6
`define HRF_RST_XCVR      7
`define HRF_RST_ALL       0
`define HRF_HOST_VBUS     7

// reset values
`define HRF_RST_CHIP_RST  8'h80
`define HRF_RST_ZERO      8'h00

// power states
`define HRF_PM_SLEEP      2'b00
`define HRF_PM_WAKING     2'b01
`define HRF_PM_ACTIVE     2'b10

// bits kept visible while asleep, per register class
`define HRF_KEEP_IRQ      8'hff
`define HRF_KEEP_PM       8'hff
`define HRF_KEEP_OTHER    8'h00

`endif

/* hw/hrf_regs.v */
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "hrf_map.vh"

module hrf_regs #(
    parameter [7:0] REVISION = 8'h5a   // arbitrary value, stands in for the silicon code
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    input  wire [7:0]  dev_event,
    input  wire [7:0]  host_event,
    input  wire [7:0]  cpu_event,
    input  wire [7:0]  fifo_event,
    input  wire        dma_count_wrap,
    output wire        irq,
    output wire        cpu_endian,
    output wire        host_bus_width_select,
    output wire        init_done,
    output wire [1:0]  current_power_state,
    output wire        transceiver_macro_reset,
    output wire        whole_chip_soft_reset,
    output wire        host_bus_power_enable,
    output wire [15:0] wake_timer_value
);

    // configuration and state flip-flops, then the combinational read decode
    reg        init_done_ff;      // leaves 0 once the initial register is written
    reg        endian_ff;         // captured byte order
    reg        busw_ff;           // captured bus mode
    reg [7:0]  dev_st_ff;         // device side sticky status
    reg [7:0]  host_st_ff;        // host side sticky status
    reg [7:0]  cpu_st_ff;         // processor path sticky status
    reg [7:0]  fifo_st_ff;        // queue sticky status
    reg        pm_done_ff;        // power transition done, sticky
    reg [7:0]  main_en_ff;        // main enables
    reg [7:0]  dev_en_ff;         // device side enables
    reg [7:0]  host_en_ff;        // host side enables
    reg [7:0]  cpu_en_ff;         // processor path enables
    reg [7:0]  fifo_en_ff;        // queue enables
    reg        xcvr_rst_ff;       // transceiver reset level
    reg        all_rst_ff;        // one-cycle soft reset pulse
    reg [1:0]  current_power_state_ff;       // current power state
    reg [15:0] wake_cnt_ff;       // wake-up countdown
    reg [7:0]  wake_hi_ff;        // wake timer upper byte
    reg [7:0]  wake_lo_ff;        // wake timer lower byte
    reg        vbus_en_ff;        // host bus power
    reg [31:0] prdata_ff;         // read data captured in setup
    reg [7:0]  rd_val;            // combinational read value
    reg        rd_hit;            // address maps to a register

    // reset image of the chip reset byte, so one bit can be picked without a shift
    localparam [7:0] CHIP_RST_INIT = `HRF_RST_CHIP_RST;

    wire [9:0] idx      = paddr[11:2];
    wire       setup_rd = psel & ~penable & ~pwrite;
    wire       acc      = psel & penable;
    wire       wr_acc   = acc & pwrite;
    wire       rd_acc   = acc & ~pwrite;
    wire       aligned  = (paddr[1:0] == 2'b00);
    wire [7:0] wd       = pwdata[7:0];

    // summary bits of the main status register
    wire       dev_sum  = |(dev_st_ff & dev_en_ff);
    wire       host_sum = |(host_st_ff & host_en_ff);
    wire       cpu_sum  = |(cpu_st_ff & cpu_en_ff);
    wire       fifo_sum = |(fifo_st_ff & fifo_en_ff);
    wire [7:0] main_st  = {dev_sum, host_sum, cpu_sum, fifo_sum, 3'b000, pm_done_ff};

    // write strobe per register; nothing lands before initialization
    function wr_to;
        input [9:0] i;
        begin
            wr_to = wr_acc & aligned & init_done_ff & (idx == i);
        end
    endfunction

    // clear mask for a read-clear status: only bits the reader actually saw
    function [7:0] rd_clr;
        input [9:0] i;
        begin
            rd_clr = (rd_acc & aligned & init_done_ff & (idx == i)) ? prdata_ff[7:0] : 8'h00;
        end
    endfunction

    // sticky update, a set in the clearing cycle wins
    function [7:0] sticky;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        begin
            sticky = (cur & ~clr) | set;
        end
    endfunction

    // bits that stay readable while asleep
    function [7:0] keep_mask;
        input [9:0] i;
        begin
            if (i <= `HRF_IDX_FIFO_EN)
                keep_mask = `HRF_KEEP_IRQ;
            else if (i == `HRF_IDX_PM_CTRL)
                keep_mask = `HRF_KEEP_PM;
            else
                keep_mask = `HRF_KEEP_OTHER;
        end
    endfunction

    // read decode; unmapped indices answer zero with an error
    always @* begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        if (idx == `HRF_IDX_MAIN_ST)
            rd_val = main_st;
        else if (idx == `HRF_IDX_DEV_ST)
            rd_val = dev_st_ff;
        else if (idx == `HRF_IDX_HOST_ST)
            rd_val = host_st_ff;
        else if (idx == `HRF_IDX_CPU_ST)
            rd_val = cpu_st_ff;
        else if (idx == `HRF_IDX_FIFO_ST)
            rd_val = fifo_st_ff;
        else if (idx == `HRF_IDX_MAIN_EN)
            rd_val = main_en_ff;
        else if (idx == `HRF_IDX_DEV_EN)
            rd_val = dev_en_ff;
        else if (idx == `HRF_IDX_HOST_EN)
            rd_val = host_en_ff;
        else if (idx == `HRF_IDX_CPU_EN)
            rd_val = cpu_en_ff;
        else if (idx == `HRF_IDX_FIFO_EN)
            rd_val = fifo_en_ff;
        else if (idx == `HRF_IDX_REV)
            rd_val = REVISION;
        else if (idx == `HRF_IDX_CHIP_RST)
            rd_val = {xcvr_rst_ff, 7'h00};
        else if (idx == `HRF_IDX_PM_CTRL)
            rd_val = {6'h00, current_power_state_ff};
        else if (idx == `HRF_IDX_WAKE_HI)
            rd_val = wake_hi_ff;
        else if (idx == `HRF_IDX_WAKE_LO)
            rd_val = wake_lo_ff;
        else if (idx == `HRF_IDX_HOST_CTRL)
            rd_val = {vbus_en_ff, 7'h00};
        else
            rd_hit = 1'b0;    // the write-only initial register reads as unmapped too
    end

    // read data is latched in setup, so the access phase never waits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_rd) begin
            if (!init_done_ff || !aligned)
                prdata_ff <= 32'h00000000;
            else if (current_power_state_ff == `HRF_PM_ACTIVE)
                prdata_ff <= {24'h000000, rd_val};
            else
                prdata_ff <= {24'h000000, rd_val & keep_mask(idx)};
        end
    end

    // one-shot initial configuration capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done_ff <= 1'b0;
            endian_ff    <= 1'b0;
            busw_ff      <= 1'b0;
        end else if (wr_acc && !init_done_ff) begin
            // any address is taken as the initial register
            endian_ff    <= pwdata[`HRF_INIT_ENDIAN];
            busw_ff      <= pwdata[`HRF_INIT_BUSW];
            init_done_ff <= 1'b1;
        end
        // once set, nothing returns here, so later writes cannot touch the capture
    end

    // sticky status; a soft reset clears them like a hard one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_st_ff  <= `HRF_RST_ZERO;
            host_st_ff <= `HRF_RST_ZERO;
            cpu_st_ff  <= `HRF_RST_ZERO;
            fifo_st_ff <= `HRF_RST_ZERO;
        end else if (all_rst_ff) begin
            dev_st_ff  <= `HRF_RST_ZERO;
            host_st_ff <= `HRF_RST_ZERO;
            cpu_st_ff  <= `HRF_RST_ZERO;
            fifo_st_ff <= `HRF_RST_ZERO;
        end else begin
            dev_st_ff  <= sticky(dev_st_ff, dev_event & `HRF_DEV_BITS, rd_clr(`HRF_IDX_DEV_ST));
            host_st_ff <= sticky(host_st_ff, host_event & `HRF_HOST_BITS, rd_clr(`HRF_IDX_HOST_ST));
            // free-running counter wrap only flags, the transfer goes on
            cpu_st_ff  <= sticky(cpu_st_ff,
                                 (cpu_event | {6'h00, dma_count_wrap, 1'b0}) & `HRF_CPU_BITS,
                                 rd_clr(`HRF_IDX_CPU_ST));
            fifo_st_ff <= sticky(fifo_st_ff, fifo_event & `HRF_FIFO_BITS, rd_clr(`HRF_IDX_FIFO_ST));
        end
    end

    // enables, control bytes and soft reset pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_en_ff  <= `HRF_RST_ZERO;
            dev_en_ff   <= `HRF_RST_ZERO;
            host_en_ff  <= `HRF_RST_ZERO;
            cpu_en_ff   <= `HRF_RST_ZERO;
            fifo_en_ff  <= `HRF_RST_ZERO;
            xcvr_rst_ff <= CHIP_RST_INIT[`HRF_RST_XCVR];
            all_rst_ff  <= 1'b0;
            wake_hi_ff  <= `HRF_RST_ZERO;
            wake_lo_ff  <= `HRF_RST_ZERO;
            vbus_en_ff  <= 1'b0;
        end else begin
            // the pulse self-clears; reads of that bit always show zero
            all_rst_ff <= wr_to(`HRF_IDX_CHIP_RST) & wd[`HRF_RST_ALL];
            if (all_rst_ff) begin
                main_en_ff <= `HRF_RST_ZERO;
                dev_en_ff  <= `HRF_RST_ZERO;
                host_en_ff <= `HRF_RST_ZERO;
                cpu_en_ff  <= `HRF_RST_ZERO;
                fifo_en_ff <= `HRF_RST_ZERO;
                vbus_en_ff <= 1'b0;
            end else begin
                if (wr_to(`HRF_IDX_MAIN_EN))
                    main_en_ff <= wd & `HRF_MAIN_EN_BITS;
                if (wr_to(`HRF_IDX_DEV_EN))
                    dev_en_ff <= wd & `HRF_DEV_BITS;
                if (wr_to(`HRF_IDX_HOST_EN))
                    host_en_ff <= wd & `HRF_HOST_BITS;
                if (wr_to(`HRF_IDX_CPU_EN))
                    cpu_en_ff <= wd & `HRF_CPU_BITS;
                if (wr_to(`HRF_IDX_FIFO_EN))
                    fifo_en_ff <= wd & `HRF_FIFO_BITS;
                if (wr_to(`HRF_IDX_HOST_CTRL))
                    vbus_en_ff <= wd[`HRF_HOST_VBUS];
            end
            if (wr_to(`HRF_IDX_CHIP_RST))
                xcvr_rst_ff <= wd[`HRF_RST_XCVR];
            if (wr_to(`HRF_IDX_WAKE_HI))
                wake_hi_ff <= wd;
            if (wr_to(`HRF_IDX_WAKE_LO))
                wake_lo_ff <= wd;
        end
    end

    // power state machine; wake-up waits out the wake timer in pclk cycles
    wire go_sleep  = wr_to(`HRF_IDX_PM_CTRL) & wd[`HRF_PM_GO_SLEEP];
    wire go_active = wr_to(`HRF_IDX_PM_CTRL) & wd[`HRF_PM_GO_ACTIVE];
    reg  pm_done_set;     // a transition finished this cycle

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_power_state_ff <= `HRF_PM_SLEEP;
            wake_cnt_ff <= 16'h0000;
            pm_done_set <= 1'b0;
        end else begin
            pm_done_set <= 1'b0;
            case (current_power_state_ff)
                `HRF_PM_SLEEP: begin
                    if (go_active) begin
                        current_power_state_ff <= `HRF_PM_WAKING;
                        wake_cnt_ff <= {wake_hi_ff, wake_lo_ff};
                    end
                end
                `HRF_PM_WAKING: begin
                    if (go_sleep) begin
                        current_power_state_ff <= `HRF_PM_SLEEP;   // abort of a wake-up still completes a transition
                        pm_done_set <= 1'b1;
                    end else if (wake_cnt_ff == 16'h0000) begin
                        current_power_state_ff <= `HRF_PM_ACTIVE;
                        pm_done_set <= 1'b1;
                    end else begin
                        wake_cnt_ff <= wake_cnt_ff - 16'h0001;
                    end
                end
                `HRF_PM_ACTIVE: begin
                    if (go_sleep) begin
                        current_power_state_ff <= `HRF_PM_SLEEP;
                        pm_done_set <= 1'b1;
                    end
                end
                default: begin
                    current_power_state_ff <= `HRF_PM_SLEEP;
                end
            endcase
        end
    end

    // clear mask of a main status read; only bit 0 is sticky there
    wire [7:0] clr_main = rd_clr(`HRF_IDX_MAIN_ST);

    // power transition done flag, cleared by reading the main status; a set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pm_done_ff <= 1'b0;
        else
            pm_done_ff <= (pm_done_ff & ~clr_main[0]) | pm_done_set;
    end

    // APB answer: zero wait states; errors for unmapped, misaligned or early reads
    assign pready  = 1'b1;
    assign pslverr = acc & (~aligned | (init_done_ff & ~pwrite & ~rd_hit)
                     | (init_done_ff & pwrite & ~rd_hit & (idx != `HRF_IDX_INIT_CFG))
                     | (~init_done_ff & ~pwrite));
    assign prdata  = prdata_ff;

    // masked interrupt, high while any enabled summary is set
    assign irq = |(main_st & main_en_ff);

    assign cpu_endian              = endian_ff;
    assign host_bus_width_select   = busw_ff;
    assign init_done               = init_done_ff;
    assign current_power_state     = current_power_state_ff;
    assign transceiver_macro_reset = xcvr_rst_ff;
    assign whole_chip_soft_reset   = all_rst_ff;
    assign host_bus_power_enable   = vbus_en_ff;
    assign wake_timer_value        = {wake_hi_ff, wake_lo_ff};

endmodule // hrf_regs

/* verification/hrf_regs_chk_sva.sv */
`timescale 1ns/100ps
`include "hrf_map.vh"
module hrf_regs_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire [31:0] prdata,
    input wire        irq,
    input wire        cpu_endian,
    input wire        host_bus_width_select,
    input wire        init_done,
    input wire [1:0]  current_power_state,
    input wire        whole_chip_soft_reset
);
    reg  started_ff;                           // low only at the first edge after release
    wire acc = psel & penable;                 // apb access phase
    wire srd = psel & ~penable & ~pwrite;      // read setup, when prdata loads
    // marks the first edge after reset, where the power state must be sleep
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_uninit_error: assert property (acc && !pwrite && !init_done |-> pslverr)
        else $error("uninitialized access not refused");
    a_uninit_rdzero: assert property (srd && !init_done |=> prdata == 32'h0)
        else $error("uninitialized read returned data");
    a_init_capture: assert property (acc && pwrite && !init_done |=> init_done &&
        cpu_endian == $past(pwdata[`HRF_INIT_ENDIAN]) && host_bus_width_select == $past(pwdata[`HRF_INIT_BUSW]))
        else $error("initial word not captured");
    a_done_hold: assert property (init_done |=> init_done)
        else $error("init done dropped");
    a_cfg_frozen: assert property ($past(init_done) |-> $stable(cpu_endian) && $stable(host_bus_width_select))
        else $error("bus settings changed after init");
    a_sleep_masked: assert property (srd && current_power_state != `HRF_PM_ACTIVE &&
        paddr inside {12'h040, 12'h044, 12'h050, 12'h054, 12'h058} |=> prdata == 32'h0)
        else $error("non retained bit visible while asleep");
    a_start_sleep: assert property (!started_ff |-> current_power_state == `HRF_PM_SLEEP)
        else $error("not asleep after reset");
    a_irq_drop: assert property ($fell(irq) |-> $past(acc) || $past(whole_chip_soft_reset))
        else $error("interrupt dropped without cause");
    c_init: cover property (acc && pwrite && !init_done);
    c_irq: cover property ($rose(irq));
    c_active: cover property (current_power_state == `HRF_PM_ACTIVE);
endmodule // hrf_regs_chk

bind hrf_regs hrf_regs_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .prdata(prdata), .irq(irq),
    .cpu_endian(cpu_endian), .host_bus_width_select(host_bus_width_select), .init_done(init_done),
    .current_power_state(current_power_state), .whole_chip_soft_reset(whole_chip_soft_reset));

/* verification/hrf_host_bfm.sv */
`timescale 1ns/100ps
module hrf_host_bfm (
    input  wire        pclk,
    input  wire        pready,
    input  wire        pslverr,
    input  wire [31:0] prdata,
    output logic       psel,
    output logic       penable,
    output logic       pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // one apb transfer; an edge passes first so back to back calls never double drive
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            // waits out cycles with pready low; only the bench watchdog ends a hung transfer
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule // hrf_host_bfm

/* verification/test_host_register_front_end.sv */
`timescale 1ns/100ps
module test_host_register_front_end;
    localparam logic [7:0] REV = 8'h3c;  // arbitrary value for the revision code
    logic        pclk, presetn;
    wire         psel, penable, pwrite, pready, pslverr, irq;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    logic [7:0]  dev_ev = 8'h0, host_ev = 8'h0, cpu_ev = 8'h0, fifo_ev = 8'h0;
    logic        wrap = 1'b0;
    wire         endian, busw, done, xrst, srst, vbus;
    wire  [1:0]  pstate;
    wire  [15:0] wake;
    logic [31:0] q;
    logic        e;
    int          bad_count = 0, check_count = 0;
    hrf_regs #(.REVISION(REV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .dev_event(dev_ev), .host_event(host_ev), .cpu_event(cpu_ev), .fifo_event(fifo_ev),
        .dma_count_wrap(wrap), .irq(irq), .cpu_endian(endian), .host_bus_width_select(busw),
        .init_done(done), .current_power_state(pstate), .transceiver_macro_reset(xrst),
        .whole_chip_soft_reset(srst), .host_bus_power_enable(vbus), .wake_timer_value(wake));
    hrf_host_bfm i_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // compare and count; x never matches
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out;
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // single cycle dma counter wrap pulse
    task pulse_wrap;
        @(posedge pclk);
        wrap <= 1'b1;
        @(posedge pclk);
        wrap <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    // before init: reads refused, any address write lands in the initial word
    task sc_uninit;
        i_host.xfer(1'b0, 12'h040, 32'h0, q, e);
        chk("uninit rd", q, 32'h0);
        chk("uninit err", e, 1'b1);
        i_host.xfer(1'b1, 12'h044, 32'h0000_0400, q, e);
        #1;
        chk("init done", done, 1'b1);
        chk("endian", endian, 1'b1);
        chk("bus width", busw, 1'b0);
    endtask
    // after init the initial word is deaf
    task sc_frozen;
        i_host.xfer(1'b1, 12'h1f8, 32'h0000_0200, q, e);
        #1;
        chk("late init err", e, 1'b0);
        chk("endian kept", endian, 1'b1);
        chk("width kept", busw, 1'b0);
        i_host.xfer(1'b0, 12'h0fc, 32'h0, q, e);
        chk("unmapped err", e, 1'b1);
    endtask
    // asleep after reset: revision and chip reset read zero
    task sc_sleep;
        chk("state", pstate, 2'b00);
        i_host.xfer(1'b0, 12'h040, 32'h0, q, e);
        chk("rev asleep", q, 32'h0);
        i_host.xfer(1'b0, 12'h044, 32'h0, q, e);
        chk("chiprst asleep", q, 32'h0);
    endtask
    // wrap sets sticky status; masked and unmasked interrupt; read clears
    task sc_irq;
        i_host.xfer(1'b1, 12'h02c, 32'h0000_00ff, q, e);
        i_host.xfer(1'b0, 12'h02c, 32'h0, q, e);
        chk("cpu en mask", q, 32'h83);
        pulse_wrap();
        chk("irq masked", irq, 1'b0);
        i_host.xfer(1'b1, 12'h020, 32'h0000_0020, q, e);
        #1;
        chk("irq on", irq, 1'b1);
        i_host.xfer(1'b0, 12'h000, 32'h0, q, e);
        chk("main summary", q, 32'h20);
        i_host.xfer(1'b0, 12'h00c, 32'h0, q, e);
        #1;
        chk("cpu status", q, 32'h02);
        chk("irq cleared", irq, 1'b0);
    endtask
    // wake with a short count, then full reads
    task sc_wake;
        int n;
        i_host.xfer(1'b1, 12'h054, 32'h0000_0003, q, e);
        i_host.xfer(1'b1, 12'h048, 32'h0000_0040, q, e);
        chk("wake value", wake, 16'h0003);
        n = 0;
        while (pstate !== 2'b10 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("active", pstate, 2'b10);
        i_host.xfer(1'b0, 12'h040, 32'h0, q, e);
        chk("rev active", q, {24'h0, REV});
        i_host.xfer(1'b0, 12'h044, 32'h0, q, e);
        chk("chiprst active", q, 32'h80);
        i_host.xfer(1'b0, 12'h000, 32'h0, q, e);
        chk("pm done", q, 32'h01);
        i_host.xfer(1'b1, 12'h058, 32'h0000_0080, q, e);
        #1;
        chk("vbus", vbus, 1'b1);
    endtask
    // group events and summaries, then a soft reset clears status and enables
    task sc_soft;
        i_host.xfer(1'b1, 12'h024, 32'h0000_00ff, q, e);
        i_host.xfer(1'b1, 12'h020, 32'h0000_0080, q, e);
        @(posedge pclk);
        dev_ev <= 8'hff;
        host_ev <= 8'hff;
        fifo_ev <= 8'hff;
        @(posedge pclk);
        dev_ev <= 8'h00;
        host_ev <= 8'h00;
        fifo_ev <= 8'h00;
        @(posedge pclk);
        #1;
        chk("irq dev", irq, 1'b1);
        i_host.xfer(1'b0, 12'h000, 32'h0, q, e);
        chk("main dev only", q, 32'h80);
        i_host.xfer(1'b0, 12'h008, 32'h0, q, e);
        chk("host status", q, 32'hfb);
        i_host.xfer(1'b0, 12'h010, 32'h0, q, e);
        chk("fifo status", q, 32'h87);
        i_host.xfer(1'b1, 12'h044, 32'h0000_0001, q, e);
        #1;
        chk("soft pulse", srst, 1'b1);
        chk("xcvr low", xrst, 1'b0);
        @(posedge pclk);
        #1;
        chk("soft pulse end", srst, 1'b0);
        chk("irq after soft", irq, 1'b0);
        i_host.xfer(1'b0, 12'h004, 32'h0, q, e);
        chk("dev status clr", q, 32'h0);
        i_host.xfer(1'b0, 12'h024, 32'h0, q, e);
        chk("dev en clr", q, 32'h0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        sc_uninit();
        sc_frozen();
        sc_sleep();
        sc_irq();
        sc_wake();
        sc_soft();
        close_out();
    end
endmodule // test_host_register_front_end
